// file: dv/qh_schedule_model.sv
// queue head ring in memory, walked while async traversal is active
`timescale 1ns/10ps

module qh_schedule_model #(
  parameter int NUM_QH = 3
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic asyncTraversing,
  input wire logic hasWork,
  input wire logic [3:0] fetchGap,
  output logic qhFetched,
  output logic qhHeadMark,
  output logic txnExecuted
);
  int idx;
  int gapCnt;
  logic phase;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx <= 0;
      gapCnt <= 0;
      phase <= 1'b0;
      qhFetched <= 1'b0;
      qhHeadMark <= 1'b0;
      txnExecuted <= 1'b0;
    end else begin
      qhFetched <= 1'b0;
      txnExecuted <= 1'b0;
      // marker means nothing outside a fetch, so keep it moving
      qhHeadMark <= ~qhHeadMark;
      if (asyncTraversing && gapCnt > 0) begin
        gapCnt <= gapCnt - 1;
      end else if (asyncTraversing && !phase) begin
        qhFetched <= 1'b1;
        qhHeadMark <= (idx == 0);
        phase <= 1'b1;
      end else if (asyncTraversing) begin
        txnExecuted <= hasWork;
        idx <= (idx + 1) % NUM_QH;
        gapCnt <= int'(fetchGap);
        phase <= 1'b0;
      end
    end
  end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the async schedule traversal block
`timescale 1ns/10ps

module tb_top;
  localparam int SLEEP = 20;
  localparam logic [2:0] IDLE = 3'h1;
  localparam logic [2:0] ACT = 3'h2;
  localparam logic [2:0] SLP = 3'h4;
  logic ref_clk, reset_n, regWr, regRd, uframeStart, uframeEnd, periodicActive;
  logic [async_trav_pkg::ADDR_W-1:0] regAddr;
  logic [async_trav_pkg::DATA_W-1:0] regWrData, regRdData, rd;
  logic qhFetched, qhHeadMark, txnExecuted, hasWork;
  logic [3:0] fetchGap;
  logic asyncTraversing, asyncSleeping, reclaimFlag, startEvent, goPeriodic, nakReloadEnable;
  logic [2:0] travState, nakState;
  int num_errors, checked, n, seed;

  async_sched_traversal #(.SLEEP_CYCLES(SLEEP)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .uframeStart(uframeStart), .uframeEnd(uframeEnd),
    .periodicActive(periodicActive), .qhFetched(qhFetched), .qhHeadMark(qhHeadMark),
    .txnExecuted(txnExecuted), .asyncTraversing(asyncTraversing),
    .asyncSleeping(asyncSleeping), .travState(travState), .nakState(nakState),
    .reclaimFlag(reclaimFlag), .startEvent(startEvent), .goPeriodic(goPeriodic),
    .nakReloadEnable(nakReloadEnable));

  qh_schedule_model u_sched (.ref_clk(ref_clk), .reset_n(reset_n),
    .asyncTraversing(asyncTraversing), .hasWork(hasWork), .fetchGap(fetchGap),
    .qhFetched(qhFetched), .qhHeadMark(qhHeadMark), .txnExecuted(txnExecuted));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [31:0] expStat(logic [2:0] t, logic [2:0] k, logic r);
    return (32'(k) << async_trav_pkg::STAT_NAK_LSB) | (32'(t) << async_trav_pkg::STAT_TRAV_LSB)
      | (32'(r) << async_trav_pkg::STAT_RECLAIM_BIT);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rdreg(input logic [3:0] a);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    rd = regRdData;
  endtask

  // one-cycle frame marker pulse, then look once outputs have settled
  task automatic pulse(input logic isEnd);
    @(posedge ref_clk);
    if (isEnd) uframeEnd <= 1'b1;
    else uframeStart <= 1'b1;
    @(posedge ref_clk);
    uframeEnd <= 1'b0;
    uframeStart <= 1'b0;
    @(negedge ref_clk);
  endtask

  // bounded wait on traversal (sel 0) or nak tracker (sel 1) state
  task automatic wait_for(input int sel, input logic [2:0] exp, input int bound);
    n = 0;
    while ((sel ? nakState : travState) !== exp && n < bound) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= bound) begin
      num_errors++;
      $display("ERROR wait state expected %h seen %h", exp, sel ? nakState : travState);
      report_and_stop();
    end
  endtask

  task automatic chk_entry();
    chk("startEvent", 1, startEvent);
    chk("reclaimFlag", 1, reclaimFlag);
    chk("nakState", 3'h1, nakState);
  endtask

  task automatic chk_eof();
    pulse(1'b1);
    chk("travState", IDLE, travState);
    chk("goPeriodic", 1, goPeriodic);
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    seed = $urandom(81635);
    {reset_n, regWr, regRd, uframeStart, uframeEnd, periodicActive, hasWork} = '0;
    regAddr = '0;
    regWrData = '0;
    fetchGap = '0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk("travState", IDLE, travState);
    rdreg(async_trav_pkg::REG_STAT);
    chk("stat", expStat(IDLE, 3'h4, 1'b0), rd);
    rdreg(async_trav_pkg::REG_CTRL);
    chk("ctrl", 0, rd);
    pulse(1'b0);
    repeat (3) @(negedge ref_clk);
    chk("travState", IDLE, travState);
    // periodic work holds async off, even across the enable write
    @(posedge ref_clk);
    periodicActive <= 1'b1;
    wr(async_trav_pkg::REG_CTRL, 32'h0000_0003);
    wr(4'h8, 32'hFFFF_FFFF);
    rdreg(4'h8);
    chk("unmapped", 0, rd);
    rdreg(async_trav_pkg::REG_CTRL);
    chk("ctrl", 32'h0000_0003, rd);
    pulse(1'b0);
    repeat (4) @(negedge ref_clk);
    chk("travState", IDLE, travState);
    @(posedge ref_clk);
    periodicActive <= 1'b0;
    wait_for(0, ACT, 4);
    chk_entry();
    wait_for(1, 3'h2, 20);
    chk("reclaimFlag", 0, reclaimFlag);
    chk("nakReloadEnable", 1, nakReloadEnable);
    wait_for(0, SLP, 20);
    chk("reclaimFlag", 0, reclaimFlag);
    chk("asyncSleeping", 1, asyncSleeping);
    wait_for(0, ACT, SLEEP + 5);
    chk("sleep length", 1, n >= SLEEP && n <= SLEEP + 1);
    chk_entry();
    chk_eof();
    // end of frame while sleeping drops the pending wake
    pulse(1'b0);
    wait_for(0, SLP, 40);
    chk_eof();
    repeat (SLEEP + 5) @(negedge ref_clk);
    chk("travState", IDLE, travState);
    // queue heads with work keep the walk going
    hasWork <= 1'b1;
    pulse(1'b0);
    repeat (60) @(negedge ref_clk);
    chk("asyncTraversing", 1, asyncTraversing);
    wr(async_trav_pkg::REG_CTRL, 32'h0000_0000);
    @(negedge ref_clk);
    pulse(1'b0);
    repeat (3) @(negedge ref_clk);
    chk("travState", IDLE, travState);
    wr(async_trav_pkg::REG_CTRL, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      hasWork <= 1'($urandom);
      fetchGap <= 4'($urandom % 4);
      pulse(1'b0);
      repeat (5 + $urandom % 60) @(negedge ref_clk);
      chk("live", 1, travState === ACT || travState === SLP);
      chk_eof();
    end
    report_and_stop();
  end
endmodule

// file: rtl/async_sched_traversal.sv
// async schedule traversal control: reclamation flag, empty detect, sleep and wake
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps

module async_sched_traversal #(
  parameter int SLEEP_CYCLES = async_trav_pkg::IDLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [async_trav_pkg::ADDR_W-1:0] regAddr,
  input wire logic [async_trav_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [async_trav_pkg::DATA_W-1:0] regRdData,
  input wire logic uframeStart,
  input wire logic uframeEnd,
  input wire logic periodicActive,
  input wire logic qhFetched,
  input wire logic qhHeadMark,
  input wire logic txnExecuted,
  output logic asyncTraversing,
  output logic asyncSleeping,
  output logic [2:0] travState,
  output logic [2:0] nakState,
  output logic reclaimFlag,
  output logic startEvent,
  output logic goPeriodic,
  output logic nakReloadEnable
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic ctrlAsyncEn;
    logic ctrlPerEn;
    async_trav_pkg::trav_e trav;
    async_trav_pkg::nak_e nak;
    logic reclaim;
    logic armed;
    logic startEvent;
    logic goPeriodic;
    logic travActive;
    logic travSleep;
    logic nakReload;
    logic [async_trav_pkg::DATA_W-1:0] rdData;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic timerLoad;
  logic timerCancel;
  logic timerExpired;
  logic timerRunning;
  logic startNow;
  logic headSeen;
  logic emptyNow;
  localparam logic [async_trav_pkg::TMR_W-1:0] SLEEP_LOAD = SLEEP_CYCLES[async_trav_pkg::TMR_W-1:0];

  function automatic logic regHit(
    input logic [async_trav_pkg::ADDR_W-1:0] addr,
    input logic [async_trav_pkg::ADDR_W-1:0] offset
  );
    regHit = (addr == offset);
  endfunction

  // ***************************************************************
  // sleep timer
  // ***************************************************************
  idle_wake_timer u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(timerLoad),
    .cancel(timerCancel),
    .loadValue(SLEEP_LOAD),
    .expired(timerExpired),
    .running(timerRunning)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.startEvent = 1'b0;
    s_nxt.goPeriodic = 1'b0;
    s_nxt.rdData = async_trav_pkg::RD_ZERO;
    timerLoad = 1'b0;
    timerCancel = 1'b0;
    startNow = 1'b0;
    // fetch indications only count while walking the async list
    headSeen = qhFetched && qhHeadMark && (s_r.trav == async_trav_pkg::TRAV_ACTIVE);
    emptyNow = headSeen && !s_r.reclaim;

    // register writes
    if (regWr && regHit(regAddr, async_trav_pkg::REG_CTRL)) begin
      s_nxt.ctrlAsyncEn = regWrData[async_trav_pkg::CTRL_ASYNC_EN_BIT];
      s_nxt.ctrlPerEn = regWrData[async_trav_pkg::CTRL_PER_EN_BIT];
    end

    // register reads; unmapped addresses read zero
    if (regRd) begin
      if (regHit(regAddr, async_trav_pkg::REG_CTRL)) begin
        s_nxt.rdData[async_trav_pkg::CTRL_ASYNC_EN_BIT] = s_r.ctrlAsyncEn;
        s_nxt.rdData[async_trav_pkg::CTRL_PER_EN_BIT] = s_r.ctrlPerEn;
      end else if (regHit(regAddr, async_trav_pkg::REG_STAT)) begin
        s_nxt.rdData[async_trav_pkg::STAT_RECLAIM_BIT] = s_r.reclaim;
        s_nxt.rdData[async_trav_pkg::STAT_TRAV_LSB +: 3] = s_r.trav;
        s_nxt.rdData[async_trav_pkg::STAT_NAK_LSB +: 3] = s_r.nak;
      end
    end

    // each micro-frame re-arms one entry from not-active
    if (uframeStart) begin
      s_nxt.armed = 1'b1;
    end else if (uframeEnd) begin
      // a frame that ends unused must not leak an entry into the next one
      s_nxt.armed = 1'b0;
    end

    unique case (s_r.trav)
      async_trav_pkg::TRAV_IDLE: begin
        // periodic owns the frame start; async waits for it to finish
        if (s_r.ctrlAsyncEn && (s_r.armed || uframeStart) && !periodicActive
            && !uframeEnd) begin
          s_nxt.trav = async_trav_pkg::TRAV_ACTIVE;
          s_nxt.armed = 1'b0;
          startNow = 1'b1;
        end
      end
      async_trav_pkg::TRAV_ACTIVE: begin
        if (uframeEnd) begin
          s_nxt.trav = async_trav_pkg::TRAV_IDLE;
          s_nxt.goPeriodic = 1'b1;
        end else if (!s_r.ctrlAsyncEn) begin
          s_nxt.trav = async_trav_pkg::TRAV_IDLE;
        end else if (emptyNow) begin
          s_nxt.trav = async_trav_pkg::TRAV_SLEEP;
          timerLoad = 1'b1;
        end
        // otherwise keep walking the list
      end
      async_trav_pkg::TRAV_SLEEP: begin
        if (uframeEnd || !s_r.ctrlAsyncEn) begin
          s_nxt.trav = async_trav_pkg::TRAV_IDLE;
          s_nxt.goPeriodic = uframeEnd;
          timerCancel = 1'b1;
        end else if (timerExpired) begin
          // wake within the frame so a pending complete-split gets served
          s_nxt.trav = async_trav_pkg::TRAV_ACTIVE;
          startNow = 1'b1;
        end
      end
    endcase

    // reclamation flag: a set in the same cycle beats the clear
    // a clear is made only while the async list is being walked
    if (headSeen) begin
      s_nxt.reclaim = 1'b0;
    end
    if (txnExecuted && (s_r.trav == async_trav_pkg::TRAV_ACTIVE)) begin
      s_nxt.reclaim = 1'b1;
    end
    if (startNow) begin
      s_nxt.reclaim = 1'b1;
    end

    // nak reload tracker
    if (startNow) begin
      s_nxt.nak = async_trav_pkg::NAK_AWAIT_HEAD;
    end else if (headSeen) begin
      unique case (s_r.nak)
        async_trav_pkg::NAK_AWAIT_HEAD: s_nxt.nak = async_trav_pkg::NAK_RELOAD;
        async_trav_pkg::NAK_RELOAD: s_nxt.nak = async_trav_pkg::NAK_WAIT_START;
        async_trav_pkg::NAK_WAIT_START: s_nxt.nak = async_trav_pkg::NAK_WAIT_START;
      endcase
    end

    s_nxt.startEvent = startNow;
    s_nxt.travActive = (s_nxt.trav == async_trav_pkg::TRAV_ACTIVE);
    s_nxt.travSleep = (s_nxt.trav == async_trav_pkg::TRAV_SLEEP);
    s_nxt.nakReload = (s_nxt.nak == async_trav_pkg::NAK_RELOAD);
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r.ctrlAsyncEn <= async_trav_pkg::CTRL_ASYNC_EN_RST;
      s_r.ctrlPerEn <= async_trav_pkg::CTRL_PER_EN_RST;
      s_r.trav <= async_trav_pkg::TRAV_IDLE;
      s_r.nak <= async_trav_pkg::NAK_WAIT_START;
      s_r.reclaim <= 1'b0;
      s_r.armed <= 1'b0;
      s_r.startEvent <= 1'b0;
      s_r.goPeriodic <= 1'b0;
      s_r.travActive <= 1'b0;
      s_r.travSleep <= 1'b0;
      s_r.nakReload <= 1'b0;
      s_r.rdData <= async_trav_pkg::RD_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign regRdData = s_r.rdData;
  assign asyncTraversing = s_r.travActive;
  assign asyncSleeping = s_r.travSleep;
  assign travState = s_r.trav;
  assign nakState = s_r.nak;
  assign reclaimFlag = s_r.reclaim;
  assign startEvent = s_r.startEvent;
  assign goPeriodic = s_r.goPeriodic;
  assign nakReloadEnable = s_r.nakReload;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_head_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
    headSeen && !txnExecuted |=> !reclaimFlag)
    else $error("head marker fetch did not clear reclamation flag");

  a_txn_sets: assert property (@(posedge ref_clk) disable iff (!reset_n)
    txnExecuted && asyncTraversing |=> reclaimFlag)
    else $error("executed transaction did not set reclamation flag");

  a_start_sets: assert property (@(posedge ref_clk) disable iff (!reset_n)
    startEvent |-> reclaimFlag && asyncTraversing)
    else $error("start event without reclamation flag set");

  a_empty_sleeps: assert property (@(posedge ref_clk) disable iff (!reset_n)
    emptyNow && !uframeEnd && s_r.ctrlAsyncEn |=> asyncSleeping && !asyncTraversing)
    else $error("empty list did not enter sleeping");

  a_sleep_loads: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(asyncSleeping) |-> timerRunning)
    else $error("sleeping entered without a running timer");

  a_idle_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !s_r.ctrlAsyncEn && travState == async_trav_pkg::TRAV_IDLE
      |=> travState == async_trav_pkg::TRAV_IDLE)
    else $error("left not-active with async disabled");

  a_eof_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    uframeEnd && (asyncTraversing || asyncSleeping)
      |=> travState == async_trav_pkg::TRAV_IDLE && goPeriodic)
    else $error("end of micro-frame did not return to not-active");

  a_wake_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    timerExpired && asyncSleeping && !uframeEnd && s_r.ctrlAsyncEn
      |=> asyncTraversing && startEvent && nakState == async_trav_pkg::NAK_AWAIT_HEAD)
    else $error("timer expiry did not restart traversal");

  a_reload_after_head: assert property (@(posedge ref_clk) disable iff (!reset_n)
    startEvent ##1 (headSeen && !startNow) |=> nakReloadEnable)
    else $error("first head after start did not open reloads");

  a_sleep_cancel: assert property (@(posedge ref_clk) disable iff (!reset_n)
    asyncSleeping && uframeEnd |=> !timerRunning)
    else $error("sleep timer still running after leaving sleeping");

  // ***************************************************************
  // entry, walk and handshake checks
  // ***************************************************************
  a_idle_blocked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    travState == async_trav_pkg::TRAV_IDLE && periodicActive |=> !asyncTraversing)
    else $error("left not-active while periodic work was running");

  a_active_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
    asyncTraversing && !uframeEnd && s_r.ctrlAsyncEn
      && !(qhFetched && qhHeadMark && !reclaimFlag) |=> asyncTraversing)
    else $error("active traversal stopped without a reason");

  a_entry_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(asyncTraversing) |-> startEvent)
    else $error("active state entered without a start event");

  a_start_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    startEvent |=> !startEvent)
    else $error("start event lasted more than one cycle");

  a_start_awaits: assert property (@(posedge ref_clk) disable iff (!reset_n)
    startEvent |-> nakState == async_trav_pkg::NAK_AWAIT_HEAD)
    else $error("start event did not re-open nak reloads");

  a_reload_entry: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(nakReloadEnable) |-> $past(nakState) == async_trav_pkg::NAK_AWAIT_HEAD)
    else $error("reload state entered from the wrong state");

  a_frame_rearm: assert property (@(posedge ref_clk) disable iff (!reset_n)
    uframeStart && !uframeEnd && !periodicActive && s_r.ctrlAsyncEn
      && travState == async_trav_pkg::TRAV_IDLE |=> asyncTraversing)
    else $error("micro-frame start did not resume traversal");

  a_empty_test: assert property (@(posedge ref_clk) disable iff (!reset_n)
    asyncTraversing && qhFetched && qhHeadMark && !reclaimFlag && !uframeEnd
      && s_r.ctrlAsyncEn |=> asyncSleeping)
    else $error("empty test after head fetch did not stop the walk");

  a_sleep_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    asyncSleeping && !timerExpired |=> $stable(reclaimFlag))
    else $error("reclamation flag moved while sleeping");

  a_periodic_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n)
    periodicActive && !asyncTraversing |=> !$fell(reclaimFlag))
    else $error("reclamation flag cleared during periodic work");

  a_handover_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    goPeriodic |=> !goPeriodic)
    else $error("periodic hand-over lasted more than one cycle");

  a_read_one_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !regRd |=> regRdData == async_trav_pkg::RD_ZERO)
    else $error("read data stood without a read strobe");

endmodule

// file: rtl/async_trav_pkg.sv
// constants, register map and state encodings for the async schedule traversal block
package async_trav_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int CLK_MHZ = 40;
  // idle_interval_constant, in microseconds
  localparam int IDLE_INTERVAL_US = 10000;
  localparam int IDLE_CYCLES = IDLE_INTERVAL_US * CLK_MHZ;
  localparam int TMR_W = 19;

  // ***************************************************************
  // register port
  // ***************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;

  localparam int CTRL_ASYNC_EN_BIT = 0;
  localparam int CTRL_PER_EN_BIT = 1;
  localparam logic CTRL_ASYNC_EN_RST = 1'h0;
  localparam logic CTRL_PER_EN_RST = 1'h0;

  localparam int STAT_RECLAIM_BIT = 0;
  localparam int STAT_TRAV_LSB = 1;
  localparam int STAT_NAK_LSB = 4;

  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // ***************************************************************
  // state encodings
  // ***************************************************************
  typedef enum logic [2:0] {
    TRAV_IDLE = 3'h1,
    TRAV_ACTIVE = 3'h2,
    TRAV_SLEEP = 3'h4
  } trav_e;

  typedef enum logic [2:0] {
    NAK_AWAIT_HEAD = 3'h1,
    NAK_RELOAD = 3'h2,
    NAK_WAIT_START = 3'h4
  } nak_e;

  localparam logic [TMR_W-1:0] TMR_ZERO = 19'h0_0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 19'h0_0001;

endpackage

// file: rtl/idle_wake_timer.sv
// down-counting sleep timer with a one-cycle expiry pulse
`timescale 1ns/10ps

module idle_wake_timer (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic cancel,
  input wire logic [async_trav_pkg::TMR_W-1:0] loadValue,
  output logic expired,
  output logic running
);

  typedef struct packed {
    logic [async_trav_pkg::TMR_W-1:0] count;
    logic running;
    logic expired;
  } tmr_s;

  tmr_s s_r;
  tmr_s s_nxt;

  // ***************************************************************
  // counting
  // ***************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.expired = 1'b0;
    if (cancel) begin
      s_nxt.running = 1'b0;
      s_nxt.count = async_trav_pkg::TMR_ZERO;
    end else if (load) begin
      s_nxt.running = 1'b1;
      s_nxt.count = loadValue;
    end else if (s_r.running) begin
      // a zero load still expires, one cycle later
      if (s_r.count <= async_trav_pkg::TMR_ONE) begin
        s_nxt.running = 1'b0;
        s_nxt.expired = 1'b1;
        s_nxt.count = async_trav_pkg::TMR_ZERO;
      end else begin
        s_nxt.count = s_r.count - async_trav_pkg::TMR_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expired = s_r.expired;
  assign running = s_r.running;

  a_expiry_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
    expired |=> !expired)
    else $error("timer expiry lasted more than one cycle");

  a_cancel_stops: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cancel |=> !running && !expired)
    else $error("timer still running after cancel");

endmodule
